// *** hw/acc_pkg.sv ***
// Package of register map, field layout, commands and states for the clock controller
package acc_pkg;

	// Device register word addresses
	localparam logic [15:0] ACC_REG_PRI_CFG   = 16'h0101; // Primary clock control word
	localparam logic [15:0] ACC_REG_PRI_RATE0 = 16'h0102; // First primary rate selector
	localparam logic [15:0] ACC_REG_PRI_STS0  = 16'h010a; // First primary rate status copy
	localparam logic [15:0] ACC_REG_SEC_CFG   = 16'h0112; // Secondary clock control word
	localparam logic [15:0] ACC_REG_SEC_RATE0 = 16'h0113; // First secondary rate selector
	localparam logic [15:0] ACC_REG_SEC_STS0  = 16'h011b; // First secondary rate status copy
	localparam logic [15:0] ACC_REG_CORE_CFG  = 16'h0120; // Core clock control word

	// Field positions inside the control words
	localparam int ACC_FAMILY_BIT = 15; // Primary family select
	localparam int ACC_FREQ_LSB   = 8;  // Frequency code, three bits
	localparam int ACC_DIV6_BIT   = 7;  // Core clock low power divide select
	localparam int ACC_ON_BIT     = 6;  // Clock on bit
	localparam int ACC_SRC_LSB    = 0;  // Source select, four bits

	// Code limits
	localparam logic [2:0] ACC_FREQ_MAX = 3'h4; // Highest legal frequency code
	localparam logic [3:0] ACC_SRC_LOOP1 = 4'h4; // First frequency locked loop

	// Number of rate selectors per domain
	localparam logic [1:0] ACC_PRI_RATES = 2'h3;
	localparam logic [1:0] ACC_SEC_RATES = 2'h2;

	// Wait limit for source ready and status echo
	localparam int ACC_CLK_NS   = 4;     // Clock period in ns
	localparam int ACC_WAIT_NS  = 10000; // Longest wait in ns
	localparam logic [15:0] ACC_WAIT_CYC = 16'((ACC_WAIT_NS / ACC_CLK_NS));

	// Which clock a command reconfigures
	typedef enum logic [1:0] {
		ACC_K_PRI  = 2'h0,
		ACC_K_SEC  = 2'h1,
		ACC_K_CORE = 2'h2
	} acc_kind_t;

	// Rate code classes
	typedef enum logic [1:0] {
		ACC_RF_NONE = 2'h0,
		ACC_RF_48   = 2'h1,
		ACC_RF_44   = 2'h2,
		ACC_RF_BAD  = 2'h3
	} acc_fam_t;

	// Result codes
	typedef enum logic [2:0] {
		ACC_E_NONE    = 3'h0,
		ACC_E_FAMILY  = 3'h1,
		ACC_E_CODE    = 3'h2,
		ACC_E_DEPS    = 3'h3,
		ACC_E_TIMEOUT = 3'h4
	} acc_err_t;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		ACC_S_IDLE = 8'h01,
		ACC_S_WAIT = 8'h02,
		ACC_S_OFF  = 8'h04,
		ACC_S_CFG  = 8'h08,
		ACC_S_RATE = 8'h10,
		ACC_S_ON   = 8'h20,
		ACC_S_POLL = 8'h40,
		ACC_S_DONE = 8'h80
	} acc_state_t;

	// One reconfiguration order from the user side
	typedef struct packed {
		acc_kind_t       kind;    // Target clock
		logic            on;      // Leave clock running afterwards
		logic            use_seq; // Dependents may stay enabled
		logic [3:0]      src;     // Source select code
		logic [2:0]      freq;    // Frequency code
		logic            family;  // 1 = 44.1 kHz family
		logic            div6;    // Core clock low power divide
		logic [2:0][4:0] rate;    // Rate selector codes
	} acc_cmd_t;

endpackage

// *** hw/acc_sync3.sv ***
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module acc_sync3
	import acc_pkg::*;
(
	input  wire logic SYS_CLK,
	input  wire logic RST_B,
	input  wire logic PIN_IN,
	output logic      LEVEL_OUT
);

	logic s1_ff, s2_ff, s3_ff, lvl_ff; // Stages and filtered level
	logic nxt_lvl;                     // Next filtered level

	// Level moves only once stages two and three agree
	always_comb
	begin
		nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
	end

	// Stage one feeds only stage two
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			lvl_ff <= 1'b0;
		end
		else
		begin
			s1_ff  <= PIN_IN;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	assign LEVEL_OUT = lvl_ff;

endmodule // acc_sync3
`default_nettype wire

// *** hw/acc_ctrl.sv ***
// Host side controller that reconfigures the codec clock domains by register writes
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Primary rate codes must share one family
// R2: Secondary rate codes share one family
// R3: Secondary frequency code limited to five values
// R4: Secondary unused: keep it disabled
// R5: Device derives dividers from codes
// R6: Interface clock rates programmed separately
// R7: Source selector; loop enabled first
// R8: Loop divided by three for primary
// R9: Prefer highest primary frequency
// R10: Rates span 8 to 192 kHz
// R11: Source ready before on; off before change; the code's off write already carries the new fields
// R12: Primary on before dependents enabled
// R13: No reconfigure while dependents enabled; the code lets off orders and use_seq orders through
// R14: Keep primary for firmware and timer
// R15: Sequencer order: off, config, on
// R16: Loop divided by three for secondary
// R17: Secondary: source first, off before change; the code's off write already carries the new fields
// R18: Clocks configured before any path
// R19: Device rejects paths lacking clock cycles
// R20: Each core divides core clock
// R21: Loop divided by two for cores
// R22: Divide by six only from loop one
// R23: Core source first, off before reconfigure; the code's off write already carries the new fields
// R24: Family bit picks frequency base
// R25: Source codes; others reserved
// R26: Rate status copies confirm new rates
module acc_ctrl
	import acc_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST_B,
	input  wire acc_cmd_t   CMD,
	input  wire logic       CMD_VALID,
	output logic            CMD_READY,
	input  wire logic       DEPS_ACTIVE,
	input  wire logic       SRC_READY_PIN,
	output logic            DONE,
	output acc_err_t        ERR,
	output logic            BUSY,
	output logic [15:0]     REG_ADDR,
	output logic [15:0]     REG_WDATA,
	output logic            REG_WR,
	output logic            REG_RD,
	input  wire logic [15:0] REG_RDATA,
	input  wire logic       REG_ACK
);

	acc_state_t  state_ff, nxt_state; // Sequencer state
	acc_cmd_t    cmd_ff, nxt_cmd;     // Order being carried out
	acc_err_t    err_ff, nxt_err;     // Result of last order
	logic [1:0]  idx_ff, nxt_idx;     // Rate selector index
	logic [15:0] tmr_ff, nxt_tmr;     // Wait timer
	logic [15:0] addr_ff, nxt_addr;   // Register address out
	logic [15:0] wdat_ff, nxt_wdat;   // Register data out
	logic        src_ready;           // Filtered source ready level
	acc_err_t    chk;                 // Check result of incoming order

	// Source ready pin passes the three stage filter
	acc_sync3 acc_sync3_i (
		.SYS_CLK   (SYS_CLK),
		.RST_B     (RST_B),
		.PIN_IN    (SRC_READY_PIN),
		.LEVEL_OUT (src_ready)
	);

	// Class of one rate code
	function automatic acc_fam_t fam_of(input logic [4:0] code);
		case (code)
			5'h00:                                     fam_of = ACC_RF_NONE;
			5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
			5'h11, 5'h12, 5'h13:                       fam_of = ACC_RF_48;
			5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d:         fam_of = ACC_RF_44;
			default:                                   fam_of = ACC_RF_BAD;
		endcase
	endfunction

	// Number of rate selectors in the target domain
	function automatic logic [1:0] rate_cnt(input acc_kind_t k);
		case (k)
			ACC_K_PRI: rate_cnt = ACC_PRI_RATES;
			ACC_K_SEC: rate_cnt = ACC_SEC_RATES;
			default:   rate_cnt = 2'h0;
		endcase
	endfunction

	// Source codes the device accepts
	function automatic logic src_ok(input logic [3:0] s);
		src_ok = (s <= 4'h1) || (s >= 4'h4 && s <= 4'h6) || (s >= 4'h8 && s <= 4'hb); // R25
	endfunction

	// Control word address of the target clock
	// Interface bit clock rates are left to the user; nothing here writes them
	function automatic logic [15:0] cfg_addr(input acc_kind_t k); // R6
		case (k)
			ACC_K_PRI: cfg_addr = ACC_REG_PRI_CFG;
			ACC_K_SEC: cfg_addr = ACC_REG_SEC_CFG;
			default:   cfg_addr = ACC_REG_CORE_CFG;
		endcase
	endfunction

	// Control word with the on bit as given
	function automatic logic [15:0] cfg_word(input acc_cmd_t c, input logic on);
		logic [15:0] w;
		w = 16'h0000;
		w[ACC_SRC_LSB +: 4] = c.src;       // R7
		w[ACC_ON_BIT]       = on;
		if (c.kind == ACC_K_CORE)
			w[ACC_DIV6_BIT] = c.div6;      // R21 R22
		else
			w[ACC_FREQ_LSB +: 3] = c.freq; // R3 R5
		if (c.kind == ACC_K_PRI)
			w[ACC_FAMILY_BIT] = c.family;  // R24
		cfg_word = w;
	endfunction

	// Rate selector or status copy address
	function automatic logic [15:0] rate_addr(input acc_kind_t k, input logic [1:0] i, input logic sts);
		logic [15:0] base;
		if (k == ACC_K_PRI)
			base = sts ? ACC_REG_PRI_STS0 : ACC_REG_PRI_RATE0;
		else
			base = sts ? ACC_REG_SEC_STS0 : ACC_REG_SEC_RATE0;
		rate_addr = base + {14'h0000, i};
	endfunction

	// Check an incoming order before touching the device
	always_comb
	begin
		logic [1:0] fams; // Families seen
		fams = 2'h0;
		chk  = ACC_E_NONE;
		for (int i = 0; i < 3; i++)
		begin
			if (2'(i) < rate_cnt(CMD.kind))
			begin
				case (fam_of(CMD.rate[i]))
					ACC_RF_48:   fams[0] = 1'b1;
					ACC_RF_44:   fams[1] = 1'b1;
					ACC_RF_BAD:  chk = ACC_E_CODE; // R10
					default:     ;
				endcase
			end
		end
		// Family checks only when every code is legal, so a bad code wins
		if (chk == ACC_E_NONE)
		begin
			// Mixed families cannot share one clock
			if (fams == 2'h3)
				chk = ACC_E_FAMILY; // R1 R2
			// Primary only: family of rates must match the frequency family
			else if (CMD.kind == ACC_K_PRI && ((fams[1] && !CMD.family) || (fams[0] && CMD.family)))
				chk = ACC_E_FAMILY; // R24
		end
		if (!src_ok(CMD.src) || (CMD.kind != ACC_K_CORE && CMD.freq > ACC_FREQ_MAX))
			chk = ACC_E_CODE; // R3 R25
		// Low power divide exists on loop one only
		if (CMD.kind == ACC_K_CORE && CMD.div6 && CMD.src != ACC_SRC_LOOP1)
			chk = ACC_E_CODE; // R22
		// Undefined target would otherwise fall through to the core word
		if (CMD.kind != ACC_K_PRI && CMD.kind != ACC_K_SEC && CMD.kind != ACC_K_CORE)
			chk = ACC_E_CODE;
	end

	// Sequencer next state: wait source, off, config, rates, on, confirm
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cmd   = cmd_ff;
		nxt_err   = err_ff;
		nxt_idx   = idx_ff;
		nxt_tmr   = tmr_ff;
		case (state_ff)
			ACC_S_IDLE:
			begin
				if (CMD_VALID)
				begin
					nxt_cmd = CMD;
					nxt_idx = 2'h0;
					nxt_tmr = 16'h0000;
					nxt_err = chk;
					if (chk != ACC_E_NONE)
						nxt_state = ACC_S_DONE; // R1 R2
					else if (!CMD.on)
						nxt_state = ACC_S_OFF; // R4
					else if (DEPS_ACTIVE && !CMD.use_seq)
					begin
						// Dependents running: refuse a plain reconfigure
						nxt_err   = ACC_E_DEPS; // R13 R14
						nxt_state = ACC_S_DONE;
					end
					else
						nxt_state = ACC_S_WAIT; // R11 R17 R23
				end
			end
			ACC_S_WAIT:
			begin
				// Source must run before the clock is reopened
				nxt_tmr = tmr_ff + 16'h0001;
				if (src_ready)
					nxt_state = ACC_S_OFF; // R7 R11 R17 R23
				else if (tmr_ff == ACC_WAIT_CYC)
				begin
					nxt_err   = ACC_E_TIMEOUT;
					nxt_state = ACC_S_DONE;
				end
			end
			ACC_S_OFF:
			begin
				// Clear the on bit; the off word already carries the new fields
				if (REG_ACK)
					nxt_state = cmd_ff.on ? ACC_S_CFG : ACC_S_DONE; // R11 R15 R17 R23
			end
			ACC_S_CFG:
			begin
				if (REG_ACK)
					nxt_state = (rate_cnt(cmd_ff.kind) != 2'h0) ? ACC_S_RATE : ACC_S_ON; // R15
			end
			ACC_S_RATE:
			begin
				if (REG_ACK)
				begin
					if (idx_ff == rate_cnt(cmd_ff.kind) - 2'h1)
					begin
						nxt_idx   = 2'h0;
						nxt_state = ACC_S_ON;
					end
					else
						nxt_idx = idx_ff + 2'h1;
				end
			end
			ACC_S_ON:
			begin
				// Reopen on acknowledge; source ready is not checked again here
				if (REG_ACK)
				begin
					nxt_tmr   = 16'h0000;
					nxt_state = (rate_cnt(cmd_ff.kind) != 2'h0) ? ACC_S_POLL : ACC_S_DONE; // R12 R18
				end
			end
			ACC_S_POLL:
			begin
				// Device applies new rates at a safe moment; wait for the echo
				nxt_tmr = tmr_ff + 16'h0001;
				if (REG_ACK && REG_RDATA[4:0] == cmd_ff.rate[idx_ff])
				begin
					nxt_tmr = 16'h0000;
					if (idx_ff == rate_cnt(cmd_ff.kind) - 2'h1)
						nxt_state = ACC_S_DONE; // R26
					else
						nxt_idx = idx_ff + 2'h1;
				end
				else if (tmr_ff == ACC_WAIT_CYC)
				begin
					nxt_err   = ACC_E_TIMEOUT;
					nxt_state = ACC_S_DONE;
				end
			end
			ACC_S_DONE:
				nxt_state = ACC_S_IDLE;
			default:
				nxt_state = ACC_S_IDLE;
		endcase
	end

	// Address and data for the access of the coming state
	always_comb
	begin
		nxt_addr = 16'h0000;
		nxt_wdat = 16'h0000;
		case (nxt_state)
			ACC_S_OFF:
			begin
				nxt_addr = cfg_addr(nxt_cmd.kind);
				nxt_wdat = cfg_word(nxt_cmd, 1'b0); // R11
			end
			ACC_S_CFG:
			begin
				nxt_addr = cfg_addr(nxt_cmd.kind);
				nxt_wdat = cfg_word(nxt_cmd, 1'b0); // R15
			end
			ACC_S_RATE:
			begin
				nxt_addr = rate_addr(nxt_cmd.kind, nxt_idx, 1'b0);
				nxt_wdat = {11'h000, nxt_cmd.rate[nxt_idx]}; // R5
			end
			ACC_S_ON:
			begin
				nxt_addr = cfg_addr(nxt_cmd.kind);
				nxt_wdat = cfg_word(nxt_cmd, 1'b1); // R15
			end
			ACC_S_POLL:
				nxt_addr = rate_addr(nxt_cmd.kind, nxt_idx, 1'b1); // R26
			default:
				nxt_addr = 16'h0000;
		endcase
	end

	// State registers
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			state_ff <= ACC_S_IDLE;
			cmd_ff   <= '0;
			err_ff   <= ACC_E_NONE;
			idx_ff   <= 2'h0;
			tmr_ff   <= 16'h0000;
			addr_ff  <= 16'h0000;
			wdat_ff  <= 16'h0000;
		end
		else
		begin
			state_ff <= nxt_state;
			cmd_ff   <= nxt_cmd;
			err_ff   <= nxt_err;
			idx_ff   <= nxt_idx;
			tmr_ff   <= nxt_tmr;
			addr_ff  <= nxt_addr;
			wdat_ff  <= nxt_wdat;
		end
	end

	// Handshakes from state, data from flip-flops
	assign REG_WR    = (state_ff == ACC_S_OFF) || (state_ff == ACC_S_CFG) ||
	                   (state_ff == ACC_S_RATE) || (state_ff == ACC_S_ON);
	assign REG_RD    = (state_ff == ACC_S_POLL);
	assign REG_ADDR  = addr_ff;
	assign REG_WDATA = wdat_ff;
	assign CMD_READY = (state_ff == ACC_S_IDLE);
	assign BUSY      = (state_ff != ACC_S_IDLE);
	assign DONE      = (state_ff == ACC_S_DONE);
	assign ERR       = err_ff;

	// Off write then config write, the start of every reconfigure that leaves the clock on
	sequence s_off_then_cfg;
		(state_ff == ACC_S_OFF && REG_ACK && cmd_ff.on) ##1 (state_ff == ACC_S_CFG);
	endsequence

	property p_off_before_cfg;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(state_ff == ACC_S_CFG && $past(state_ff) != ACC_S_CFG) |-> $past(state_ff) == ACC_S_OFF;
	endproperty
	a_off_before_cfg: assert property (p_off_before_cfg) else $error("config written without prior off"); // R11

	property p_off_word_clear;
		@(posedge SYS_CLK) disable iff (!RST_B)
		s_off_then_cfg |-> !REG_WDATA[ACC_ON_BIT] && REG_ADDR == $past(REG_ADDR);
	endproperty
	a_off_word_clear: assert property (p_off_word_clear) else $error("config word carries on bit"); // R15

	property p_on_needs_ready;
		@(posedge SYS_CLK) disable iff (!RST_B)
		// A source not seen running holds every write back
		(state_ff == ACC_S_WAIT && !src_ready) |=> !REG_WR;
	endproperty
	a_on_needs_ready: assert property (p_on_needs_ready) else $error("clock reopened before source ready"); // R17

	property p_reject_mix;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(CMD_READY && CMD_VALID && chk == ACC_E_FAMILY) |=> DONE && ERR == ACC_E_FAMILY && !REG_WR;
	endproperty
	a_reject_mix: assert property (p_reject_mix) else $error("mixed rate families not refused"); // R1

	property p_deps_refused;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(CMD_READY && CMD_VALID && chk == ACC_E_NONE && CMD.on && DEPS_ACTIVE && !CMD.use_seq)
		|=> DONE ##1 !REG_WR;
	endproperty
	a_deps_refused: assert property (p_deps_refused) else $error("reconfigure with dependents running"); // R13

	property p_write_holds;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(REG_WR && !REG_ACK) |=> REG_WR && $stable(REG_ADDR) && $stable(REG_WDATA);
	endproperty
	a_write_holds: assert property (p_write_holds) else $error("write dropped before acknowledge"); // R15

	property p_div6_loop1;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(REG_WR && REG_ADDR == ACC_REG_CORE_CFG && REG_WDATA[ACC_DIV6_BIT])
		|-> REG_WDATA[ACC_SRC_LSB +: 4] == ACC_SRC_LOOP1;
	endproperty
	a_div6_loop1: assert property (p_div6_loop1) else $error("divide by six on wrong source"); // R22

	property p_done_after_echo;
		@(posedge SYS_CLK) disable iff (!RST_B)
		(state_ff == ACC_S_POLL && nxt_state == ACC_S_DONE && err_ff == ACC_E_NONE && nxt_err == ACC_E_NONE)
		|-> REG_ACK ##1 DONE ##1 CMD_READY;
	endproperty
	a_done_after_echo: assert property (p_done_after_echo) else $error("done without status echo"); // R26

endmodule // acc_ctrl
`default_nettype wire

// *** verification/acc_dev_model.sv ***
// Behavioural codec register model that answers the controller's register link
`timescale 1ns/1ps
`default_nettype none
module acc_dev_model
	import acc_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [15:0]      REG_RDATA,
	output logic             REG_ACK,
	input  wire logic [3:0]  ACK_DLY,
	input  wire logic        STALE
);
	logic [15:0] mem [0:255]; // Word store of page 01h
	logic [3:0]  cnt;         // Cycles waited on this access
	logic [15:0] last;        // Word handed out on the last access, read or write
	wire  [7:0]  a = REG_ADDR[7:0];

	// Bus not acknowledging shows the inverse, so a stale sample never passes
	assign REG_RDATA = REG_ACK ? last : ~last;

	// One access per acknowledge, with a settable wait
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			REG_ACK <= 1'b0;
			cnt     <= 4'h0;
			last    <= 16'h0000;
			for (int i = 0; i < 256; i++)
				mem[i] <= 16'h0000;
		end
		else if (REG_ACK)
		begin
			REG_ACK <= 1'b0;
			cnt     <= 4'h0;
			// Write lands at the acknowledging edge
			if (REG_WR && REG_ADDR[15:8] == 8'h01)
			begin
				mem[a] <= REG_WDATA;
				// Status copy follows a rate selector; STALE holds it back to force a timeout
				if (!STALE && ((a >= 8'h02 && a <= 8'h04) || a == 8'h13 || a == 8'h14))
					mem[a + 8'h08] <= {11'h000, REG_WDATA[4:0]};
			end
		end
		else if (REG_WR || REG_RD)
		begin
			if (cnt >= ACK_DLY)
			begin
				REG_ACK <= 1'b1;
				// Unmapped pages read as zero
				last    <= (REG_ADDR[15:8] == 8'h01) ? mem[a] : 16'h0000;
			end
			else
				cnt <= cnt + 4'h1;
		end
	end
endmodule // acc_dev_model
`default_nettype wire

// *** verification/acc_ctrl_tb.sv ***
// Self-checking bench of the clock controller against the register model
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_tb
	import acc_pkg::*;
;
	logic        SYS_CLK   = 1'b0; // 250 MHz
	logic        RST_B     = 1'b0; // Synchronous, active low
	acc_cmd_t    cmd       = '0;   // Order to the controller
	logic        cmd_valid = 1'b0; // Order request
	logic        deps      = 1'b0; // Dependents enabled
	logic        src_rdy   = 1'b0; // Chosen source running
	logic [3:0]  dly       = 4'h0; // Model acknowledge wait
	logic        stale     = 1'b0; // Model withholds status echo
	logic        cmd_ready, done, busy, reg_wr, reg_rd, reg_ack;
	acc_err_t    err, got;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic [31:0] wlog [$];         // Acknowledged writes, address and data
	int          errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	acc_ctrl acc_ctrl_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CMD(cmd), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .DEPS_ACTIVE(deps), .SRC_READY_PIN(src_rdy), .DONE(done), .ERR(err),
		.BUSY(busy), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .REG_ACK(reg_ack));
	acc_dev_model acc_dev_model_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.REG_ACK(reg_ack), .ACK_DLY(dly), .STALE(stale));

	// Clock
	always #2 SYS_CLK = ~SYS_CLK;

	// Record each write when the model takes it
	always @(posedge SYS_CLK)
		if (reg_wr === 1'b1 && reg_ack === 1'b1)
			wlog.push_back({reg_addr, reg_wdata});

	// Hang guard: one source wait timeout, one echo timeout plus short orders fit well inside
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			$display("MISMATCH %0t run did not finish", $time);
			finish_test();
		end
	end

	task automatic finish_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
		end
	endtask

	function automatic acc_cmd_t mk(input acc_kind_t k, input int on, input int sq, input logic [3:0] s,
		input logic [2:0] f, input int fm, input int d6, input logic [4:0] r0, r1, r2);
		mk = '{k, 1'(on), 1'(sq), s, f, 1'(fm), 1'(d6), {r2, r1, r0}};
	endfunction

	// Expected control word from its fields
	function automatic logic [15:0] wd(input logic fm, input logic [2:0] f, input logic d6, input logic on,
		input logic [3:0] s);
		wd = {fm, 4'h0, f, d6, on, 2'h0, s};
	endfunction

	// Hand one order over, then wait for its result
	task automatic run(input acc_cmd_t c);
		int   n;
		logic ok;
		n = 0;
		wlog.delete();
		@(negedge SYS_CLK);
		cmd = c;
		cmd_valid = 1'b1;
		do
		begin
			ok = (cmd_ready === 1'b1);
			@(posedge SYS_CLK);
			n++;
		end
		while (!ok && n < 100);
		@(negedge SYS_CLK);
		cmd_valid = 1'b0;
		cmp(busy, 1'b1, "busy after take");
		// DONE lasts one cycle, so look every cycle
		while (done !== 1'b1 && n < 8000)
		begin
			@(negedge SYS_CLK);
			n++;
		end
		got = err;
		cmp(done, 1'b1, "no done");
	endtask

	task automatic chk_wr(input int i, input logic [15:0] a, input logic [15:0] d, input logic [15:0] msk);
		logic [31:0] g;
		g = (i < wlog.size()) ? wlog[i] : 32'hffff_ffff;
		cmp({g[31:16], g[15:0] & msk}, {a, d & msk}, "write word");
	endtask

	// Accepted order: off, config, rates, on, then status echo
	task automatic t_good(input acc_cmd_t c, input int nr, input logic [15:0] ca, input logic [15:0] ra);
		logic fm;
		fm = (c.kind == ACC_K_PRI) && c.family;
		run(c);
		cmp(got, ACC_E_NONE, "good result");
		cmp(wlog.size(), 3 + nr, "write count");
		chk_wr(0, ca, 16'h0000, 16'h0040);
		chk_wr(1, ca, wd(fm, c.freq, c.div6, 1'b0, c.src), 16'hffff);
		for (int i = 0; i < nr; i++)
			chk_wr(2 + i, ra + 16'(i), {11'h000, c.rate[i]}, 16'h001f);
		chk_wr(2 + nr, ca, wd(fm, c.freq, c.div6, 1'b1, c.src), 16'hffff);
	endtask

	// Refused order: result code and no register writes
	task automatic t_bad(input acc_cmd_t c, input acc_err_t e);
		run(c);
		cmp(got, e, "refusal code");
		cmp(wlog.size(), 0, "refused but wrote");
	endtask

	initial
	begin
		repeat (8) @(negedge SYS_CLK);
		RST_B = 1'b1;
		cmp(cmd_ready, 1'b1, "ready after reset");
		cmp(busy, 1'b0, "busy after reset");
		src_rdy = 1'b1;
		t_good(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h05, 5'h11), 3, ACC_REG_PRI_CFG, ACC_REG_PRI_RATE0);
		dly = 4'h3;
		t_good(mk(ACC_K_PRI, 1, 0, 4'h0, 3'h4, 1, 0, 5'h09, 5'h0b, 5'h0d), 3, ACC_REG_PRI_CFG, ACC_REG_PRI_RATE0);
		t_good(mk(ACC_K_SEC, 1, 0, 4'h8, 3'h3, 1, 0, 5'h0a, 5'h0c, 5'h00), 2, ACC_REG_SEC_CFG, ACC_REG_SEC_RATE0);
		t_good(mk(ACC_K_CORE, 1, 0, 4'h4, 3'h0, 0, 1, 5'h00, 5'h00, 5'h00), 0, ACC_REG_CORE_CFG, 16'h0000);
		t_good(mk(ACC_K_CORE, 1, 0, 4'h5, 3'h0, 0, 0, 5'h00, 5'h00, 5'h00), 0, ACC_REG_CORE_CFG, 16'h0000);
		deps = 1'b1;
		t_bad(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h05, 5'h11), ACC_E_DEPS);
		t_good(mk(ACC_K_PRI, 1, 1, 4'h5, 3'h4, 0, 0, 5'h03, 5'h05, 5'h11), 3, ACC_REG_PRI_CFG, ACC_REG_PRI_RATE0);
		deps = 1'b0;
		run(mk(ACC_K_PRI, 0, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h05, 5'h11));
		cmp(got, ACC_E_NONE, "off result");
		cmp(wlog.size(), 1, "off write count");
		chk_wr(0, ACC_REG_PRI_CFG, 16'h0000, 16'h0040);
		t_bad(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h0b, 5'h00), ACC_E_FAMILY);
		t_bad(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h09, 5'h00, 5'h00), ACC_E_FAMILY);
		t_bad(mk(ACC_K_SEC, 1, 0, 4'h4, 3'h4, 0, 0, 5'h02, 5'h0c, 5'h00), ACC_E_FAMILY);
		t_bad(mk(ACC_K_SEC, 1, 0, 4'h4, 3'h5, 0, 0, 5'h03, 5'h00, 5'h00), ACC_E_CODE);
		t_bad(mk(ACC_K_PRI, 1, 0, 4'h2, 3'h4, 0, 0, 5'h03, 5'h00, 5'h00), ACC_E_CODE);
		t_bad(mk(ACC_K_PRI, 1, 0, 4'hc, 3'h4, 0, 0, 5'h03, 5'h00, 5'h00), ACC_E_CODE);
		t_bad(mk(ACC_K_CORE, 1, 0, 4'h5, 3'h0, 0, 1, 5'h00, 5'h00, 5'h00), ACC_E_CODE);
		// Reserved rate code outranks the family clash
		t_bad(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h0b, 5'h1f), ACC_E_CODE);
		// Undefined target clock is refused
		t_bad(mk(acc_kind_t'(2'h3), 1, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h00, 5'h00), ACC_E_CODE);
		// Source not running: no write may go out before the wait expires
		src_rdy = 1'b0;
		// Let the three stage filter see the source stop first
		repeat (6) @(negedge SYS_CLK);
		t_bad(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h03, 5'h05, 5'h11), ACC_E_TIMEOUT);
		src_rdy = 1'b1;
		// Rates written but never echoed back
		stale = 1'b1;
		run(mk(ACC_K_PRI, 1, 0, 4'h4, 3'h4, 0, 0, 5'h04, 5'h02, 5'h01));
		cmp(got, ACC_E_TIMEOUT, "echo wait result");
		cmp(wlog.size(), 6, "echo wait write count");
		stale = 1'b0;
		finish_test();
	end
endmodule // acc_ctrl_tb
`default_nettype wire
